// ---- sim/dma_window_read_prefetch_ctrl_asserts.sv ----
`timescale 1ns/10ps
`include "prefetch_ctrl_regs.svh"
// watches the register port and the request handshake
module dma_window_read_prefetch_ctrl_asserts
(
   input wire logic clock,
   input wire logic reset,
   input wire logic plain_slave_mode,
   input wire logic generic_slave_primary_mode,
   input wire logic generic_dual_primary_mode,
   input wire logic [`CFG_ADDR_WIDTH-1:0] cfg_address,
   input wire logic cfg_read,
   input wire logic [`CFG_DATA_WIDTH-1:0] cfg_read_data,
   input wire logic request_valid,
   input wire logic request_in_dma_window,
   input wire logic request_accepted,
   input wire logic request_retry,
   input wire logic window_controls_used,
   input wire logic [2:0] outstanding
);
   // register is live only in a generic mode
   wire logic live = !plain_slave_mode && (generic_slave_primary_mode || generic_dual_primary_mode);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////////////
   a_reserved_bits_zero: assert property ($past(cfg_read) |-> cfg_read_data[31:22] == 0 && cfg_read_data[15:12] == 0)
      else $error("reserved bits read nonzero");
   a_dead_mode_zero: assert property ($past(cfg_read) && !$past(live) |-> cfg_read_data == 0)
      else $error("read in reserved mode nonzero");
   a_read_data_idle: assert property (!$past(cfg_read) |-> cfg_read_data == 0)
      else $error("read data outside its cycle");
   a_unmapped_zero: assert property ($past(cfg_read) && $past(cfg_address) != `DMA_WIN_CTRL_OFFSET |-> cfg_read_data == 0)
      else $error("unmapped read nonzero");
   a_window_choice: assert property (request_accepted && $past(live) |-> window_controls_used == $past(request_in_dma_window))
      else $error("wrong control set chosen");
   a_accept_cause: assert property (request_accepted |-> $past(request_valid))
      else $error("accept without request");
   a_retry_cause: assert property (request_retry |-> $past(request_valid))
      else $error("retry without request");
   a_accept_or_retry: assert property (!(request_accepted && request_retry))
      else $error("accept and retry together");
   a_accept_single: assert property (request_accepted |=> !request_accepted)
      else $error("accept longer than one cycle");
   a_slot_range: assert property (outstanding <= 3'h4)
      else $error("too many delayed requests");
endmodule

// ---- sim/dma_window_read_prefetch_ctrl_bench.sv ----
`timescale 1ns/10ps
`include "prefetch_ctrl_regs.svh"
module dma_window_read_prefetch_ctrl_bench;
   typedef struct
   {
      logic [31:0] ctrl;
      logic [1:0] cmd;
      logic win;
      int dels;
      int init;
      logic [31:0] fetch;
      logic single;
   } row_type;
   logic clock = 0, reset = 1, warm_reset = 0, plain_slave_mode = 0, generic_slave_primary_mode = 1;
   logic generic_dual_primary_mode = 0, cfg_write = 0, cfg_read = 0, request_valid = 0, slow = 0;
   logic request_in_dma_window = 0, line_delivered = 0, request_done = 0;
   logic [7:0] cfg_address = 8'h00;
   logic [31:0] cfg_write_data = 32'h0, cfg_read_data;
   logic [1:0] request_cmd = 2'h0;
   logic [23:0] default_controls = 24'h000001;
   logic line_fetched, request_accepted, request_retry, fetch_line, reconnect_allowed, single_word_only;
   logic window_controls_used;
   logic [2:0] outstanding;
   int miscompares = 0, samples_checked = 0;
   row_type rows [10];
   ////////////////////////////////////////////////////////////////////////////////
   dma_window_read_prefetch_ctrl dut (.clock(clock), .reset(reset), .warm_reset(warm_reset),
      .plain_slave_mode(plain_slave_mode), .generic_slave_primary_mode(generic_slave_primary_mode),
      .generic_dual_primary_mode(generic_dual_primary_mode), .cfg_address(cfg_address),
      .cfg_write_data(cfg_write_data), .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_read_data(cfg_read_data),
      .request_valid(request_valid), .request_in_dma_window(request_in_dma_window), .request_cmd(request_cmd),
      .default_controls(default_controls), .line_fetched(line_fetched), .line_delivered(line_delivered),
      .request_done(request_done), .request_accepted(request_accepted), .request_retry(request_retry),
      .fetch_line(fetch_line), .reconnect_allowed(reconnect_allowed), .single_word_only(single_word_only),
      .window_controls_used(window_controls_used), .outstanding(outstanding));
   link_memory_model memory (.clock(clock), .reset(reset), .fetch_line(fetch_line), .slow(slow),
      .line_fetched(line_fetched));
   // free running clock
   initial forever #20 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_flag(input logic got, input logic exp);
      cmp_data({31'h0, got}, {31'h0, exp});
   endtask
   task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      cfg_address <= a;
      cfg_write_data <= d;
      cfg_write <= 1'b1;
      @(posedge clock);
      cfg_write <= 1'b0;
   endtask
   task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      cfg_address <= a;
      cfg_read <= 1'b1;
      @(posedge clock);
      cfg_read <= 1'b0;
      #1 cmp_data(cfg_read_data, exp);
   endtask
   // one request: count returned lines, deliver some, poke a second request
   task automatic run_req(input row_type r);
      logic [31:0] got;
      logic early;
      logic seen;
      got = 0;
      early = 0;
      seen = 0;
      @(posedge clock);
      request_valid <= 1'b1;
      request_cmd <= r.cmd;
      request_in_dma_window <= r.win;
      @(posedge clock);
      request_valid <= 1'b0;
      #1 cmp_flag(request_accepted, 1'b1);
      cmp_flag(single_word_only, r.single);
      for (int i = 0; i < 60; i++)
      begin
         @(posedge clock);
         line_delivered <= (i >= 30 && i < 30 + r.dels);
         request_valid <= (i == 50);
         @(negedge clock);
         if (i == 51)
            cmp_flag(request_retry, 1'b1);
         if (i == 5)
            cmp_data({29'h0, outstanding}, 32'h1);
         if (reconnect_allowed === 1'b1 && got < r.init)
            early = 1;
         seen |= (reconnect_allowed === 1'b1);
         if (line_fetched === 1'b1)
            got++;
      end
      request_done <= 1'b1;
      @(posedge clock);
      request_done <= 1'b0;
      repeat (3) @(posedge clock);
      if (!r.single)
      begin
         cmp_data(got, r.fetch);
         cmp_flag(early, 1'b0);
         cmp_flag(seen, 1'b1);
      end
   endtask
   task automatic report_and_stop();
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // hang guard
   initial
   begin
      #400000;
      miscompares++;
      report_and_stop();
   end
   // main sequence: table rows, then reset and refusal cases
   initial
   begin
      rows[0] = '{32'h00100049, 2'h1, 1'b1, 0, 2, 32'h3, 1'b0};
      rows[1] = '{32'h00100849, 2'h1, 1'b1, 2, 2, 32'h5, 1'b0};
      rows[2] = '{32'h0001000D, 2'h2, 1'b1, 0, 1, 32'h4, 1'b0};
      rows[3] = '{32'h0001040D, 2'h2, 1'b1, 3, 1, 32'h7, 1'b0};
      rows[4] = '{32'h00000049, 2'h0, 1'b1, 0, 0, 32'h0, 1'b1};
      rows[5] = '{32'h0000004B, 2'h0, 1'b1, 0, 0, 32'h3, 1'b0};
      rows[6] = '{32'h00000048, 2'h1, 1'b1, 0, 0, 32'h0, 1'b1};
      rows[7] = '{32'h000000FD, 2'h1, 1'b0, 0, 0, 32'h1, 1'b0};
      rows[8] = '{32'hFFC0F049, 2'h1, 1'b1, 0, 0, 32'h3, 1'b0};
      rows[9] = '{32'h00180001, 2'h1, 1'b1, 0, 3, 32'h3, 1'b0};
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      cfg_rd(8'h5C, 32'h1);
      foreach (rows[i])
      begin
         slow <= (i % 2 == 1);
         cfg_wr(8'h5C, rows[i].ctrl);
         cfg_rd(8'h5C, {8'h0, rows[i].ctrl[23:0] & `DMA_WIN_CTRL_MASK});
         run_req(rows[i]);
         $display("test %0d done", i);
      end
      cfg_wr(8'h5C, 32'h00FFFFFF);
      warm_reset <= 1'b1;
      @(posedge clock);
      warm_reset <= 1'b0;
      cfg_rd(8'h5C, 32'h1);
      cfg_wr(8'h5C, 32'h00FFFFFF);
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      cfg_rd(8'h5C, 32'h1);
      cfg_wr(8'h5A, 32'hFFFFFFFF);
      cfg_rd(8'h5A, 32'h0);
      plain_slave_mode <= 1'b1;
      cfg_wr(8'h5C, 32'h003F0FFE);
      cfg_rd(8'h5C, 32'h0);
      plain_slave_mode <= 1'b0;
      generic_slave_primary_mode <= 1'b0;
      generic_dual_primary_mode <= 1'b1;
      cfg_rd(8'h5C, 32'h1);
      generic_dual_primary_mode <= 1'b0;
      cfg_rd(8'h5C, 32'h0);
      $display("reset and mode tests done");
      report_and_stop();
   end
endmodule
bind dma_window_read_prefetch_ctrl dma_window_read_prefetch_ctrl_asserts checker_inst (.clock(clock), .reset(reset),
   .plain_slave_mode(plain_slave_mode), .generic_slave_primary_mode(generic_slave_primary_mode),
   .generic_dual_primary_mode(generic_dual_primary_mode), .cfg_address(cfg_address), .cfg_read(cfg_read),
   .cfg_read_data(cfg_read_data), .request_valid(request_valid), .request_in_dma_window(request_in_dma_window),
   .request_accepted(request_accepted), .request_retry(request_retry),
   .window_controls_used(window_controls_used), .outstanding(outstanding));

// ---- sim/link_memory_model.sv ----
`timescale 1ns/10ps
// link side memory: returns each asked line after a short or long delay
module link_memory_model
(
   input wire logic clock,
   input wire logic reset,
   input wire logic fetch_line,
   input wire logic slow,
   output logic line_fetched
);
   logic [2:0] wait_count;
   // the gap after each pulse lets the registered request drop first
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         wait_count <= 3'h0;
         line_fetched <= 1'b0;
      end
      else
      begin
         line_fetched <= 1'b0;
         if (!fetch_line || line_fetched)
            wait_count <= 3'h0;
         else if (wait_count == (slow ? 3'h4 : 3'h1))
         begin
            line_fetched <= 1'b1;
            wait_count <= 3'h0;
         end
         else
            wait_count <= wait_count + 3'h1;
      end
   end
endmodule

// ---- src/delayed_slot_counter.sv ----
`timescale 1ns/10ps
`include "prefetch_ctrl_regs.svh"
// counts outstanding delayed requests against a programmed limit
module delayed_slot_counter
#(
   parameter int slots = 4
)
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [1:0] limit_code,
   input wire logic take,
   input wire logic give,
   output logic full,
   output logic [`SLOT_COUNT_WIDTH-1:0] used
);
   typedef struct packed
   {
      logic [`SLOT_COUNT_WIDTH-1:0] used;
   } slot_state_type;

   slot_state_type state;
   slot_state_type next_state;
   logic [`SLOT_COUNT_WIDTH-1:0] allowed;
   logic [`SLOT_COUNT_WIDTH-1:0] requested;

   // refuse slot counts the counter cannot hold
   if (slots < 1 || slots > 4)
   begin
      $error("slots must be 1 to 4");
   end

   // field value plus one requests may be outstanding, never more than the buffers built
   assign requested = {1'b0, limit_code} + `SLOT_COUNT_WIDTH'(1);
   assign allowed = (requested > `SLOT_COUNT_WIDTH'(slots)) ? `SLOT_COUNT_WIDTH'(slots) : requested;
   assign full = (state.used >= allowed);
   assign used = state.used;

   // take counts up only when room remains, give counts down
   always_comb
   begin
      next_state = state;
      if (take && !full && !(give && state.used != '0))
      begin
         next_state.used = state.used + `SLOT_COUNT_WIDTH'(1);
      end
      else if (give && state.used != '0 && !(take && !full))
      begin
         next_state.used = state.used - `SLOT_COUNT_WIDTH'(1);
      end
   end

   // state register
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end
endmodule

// ---- src/dma_window_read_prefetch_ctrl.sv ----
// Local design decision: strobed register access.
`timescale 1ns/10ps
`include "prefetch_ctrl_regs.svh"
// Behaviour
// R1 - register acts only in generic slave-primary or dual-primary modes, else reads zero
// R2 - window hits use this register, other requests use the default controls
// R3 - line reads allow reconnect only after initial-count lines fetched
// R4 - multiple reads allow reconnect only after multiple initial-count lines fetched
// R5 - line continuous bit fetches one more line per delivered line
// R6 - multiple continuous bit fetches one more line per delivered line
// R7 - field plus one delayed requests may be outstanding; requests are taken only in st_idle, so at most one is outstanding
// R8 - line reads prefetch line-count lines beyond the first line; fetches the line initial count instead when that is larger
// R9 - software keeps line count not above multiple count
// R10 - multiple reads prefetch multiple-count lines beyond the first line; fetches the multiple initial count instead when that is larger
// R11 - plain reads prefetch like line reads when enabled, else one word only
// R12 - master enable clear stops all prefetching; it resets to one
// R13 - warm reset restores every writable field like cold reset
// R14 - reserved ranges read zero and writes to them have no effect
module dma_window_read_prefetch_ctrl
#(
   parameter int line_width = 4,
   parameter int slots = 4
)
(
   input wire logic clock,
   input wire logic reset,
   input wire logic warm_reset,
   input wire logic plain_slave_mode,
   input wire logic generic_slave_primary_mode,
   input wire logic generic_dual_primary_mode,
   input wire logic [`CFG_ADDR_WIDTH-1:0] cfg_address,
   input wire logic [`CFG_DATA_WIDTH-1:0] cfg_write_data,
   input wire logic cfg_write,
   input wire logic cfg_read,
   output logic [`CFG_DATA_WIDTH-1:0] cfg_read_data,
   input wire logic request_valid,
   input wire logic request_in_dma_window,
   input wire logic [1:0] request_cmd,
   input wire logic [23:0] default_controls,
   input wire logic line_fetched,
   input wire logic line_delivered,
   input wire logic request_done,
   output logic request_accepted,
   output logic request_retry,
   output logic fetch_line,
   output logic reconnect_allowed,
   output logic single_word_only,
   output logic window_controls_used,
   output logic [2:0] outstanding
);
   typedef struct packed
   {
      logic [23:0] control;
      prefetch_ctrl_pkg::fetch_state_type fsm;
      prefetch_ctrl_pkg::read_cmd_type cmd;
      logic [23:0] active;
      logic [`CFG_DATA_WIDTH-1:0] read_data;
      logic accepted;
      logic retry;
      logic fetch;
      logic reconnect;
      logic single;
      logic window_used;
      logic [2:0] outstanding;
   } ctrl_state_type;

   ctrl_state_type state;
   ctrl_state_type next_state;
   logic generic_mode;
   logic slots_full;
   logic [`SLOT_COUNT_WIDTH-1:0] slots_used;
   logic [line_width-1:0] fetched_total;
   logic [line_width-1:0] delivered_total;
   logic window_start;
   logic [23:0] chosen;
   logic [line_width-1:0] target;
   logic [line_width-1:0] initial_need;
   logic continuous;
   logic prefetching;
   logic [1:0] new_cmd;
   logic [line_width-1:0] fill_goal;
   logic [line_width:0] fetched_next;
   logic [line_width:0] window_goal;

   // refuse widths and slot counts the counters cannot serve
   if (line_width < 4)
   begin
      $error("line_width must be at least 4");
   end
   if (slots < 1 || slots > 4)
   begin
      $error("slots must be 1 to 4");
   end

   // address decode shared by reads and writes
   function automatic logic hit_control(input logic [`CFG_ADDR_WIDTH-1:0] address);
      hit_control = (address == `DMA_WIN_CTRL_OFFSET);
   endfunction

   // true when the command prefetches under the given controls
   function automatic logic does_prefetch(input logic [1:0] cmd, input logic [23:0] ctl);
      does_prefetch = ctl[`F_PREFETCH_ENABLE] &&
         (cmd == 2'h1 || cmd == 2'h2 || (cmd == 2'h0 && ctl[`F_PLAIN_PREFETCH]));
   endfunction

   // widens a three bit line field to the counter width
   function automatic logic [line_width-1:0] field_lines(input logic [2:0] field);
      field_lines = line_width'(field);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   assign generic_mode = (generic_slave_primary_mode || generic_dual_primary_mode) && !plain_slave_mode;
   // window hits pick this register only in generic modes
   assign chosen = (request_in_dma_window && generic_mode) ? state.control : default_controls; // see R2
   assign new_cmd = request_cmd;
   assign window_start = (state.fsm == prefetch_ctrl_pkg::st_idle) && request_valid && !slots_full;
   assign prefetching = does_prefetch(state.cmd, state.active); // see R11 see R12

   // totals one edge ahead; a continuous window moves up by each delivered line
   // once the fetched total saturates the fetch request keeps rising until request_done, so very long bursts fetch without limit
   always_comb
   begin
      fetched_next = {1'b0, fetched_total} + {{line_width{1'b0}}, line_fetched};
      window_goal = {1'b0, target} + {1'b0, delivered_total};
      // fetch at least as many lines as the reconnect threshold asks for
      if (initial_need > target)
      begin
         fill_goal = initial_need; // see R3 see R4
      end
      else
      begin
         fill_goal = target;
      end
   end

   // lines to fetch: first line plus count beyond it
   always_comb
   begin
      target = line_width'(1);
      initial_need = line_width'(1);
      continuous = 1'b0;
      if (state.cmd == prefetch_ctrl_pkg::cmd_multiple)
      begin
         target = field_lines(state.active[`F_MULT_COUNT_HI:`F_MULT_COUNT_LO]) + line_width'(1); // see R10
         initial_need = field_lines(state.active[`F_MULT_INIT_HI:`F_MULT_INIT_LO]); // see R4
         continuous = state.active[`F_MULT_CONT]; // see R6
      end
      else
      begin
         target = field_lines(state.active[`F_LINE_COUNT_HI:`F_LINE_COUNT_LO]) + line_width'(1); // see R8
         initial_need = field_lines(state.active[`F_LINE_INIT_HI:`F_LINE_INIT_LO]); // see R3
         continuous = state.active[`F_LINE_CONT]; // see R5
      end
      if (!prefetching)
      begin
         target = line_width'(1);
         initial_need = line_width'(1);
         continuous = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // submodules

   delayed_slot_counter #(.slots(slots)) slot_counter
   (
      .clock(clock),
      .reset(reset),
      .limit_code(chosen[`F_DELAYED_HI:`F_DELAYED_LO]), // see R7
      .take(window_start),
      .give(request_done),
      .full(slots_full),
      .used(slots_used)
   );

   line_window_counter #(.width(line_width)) window_counter
   (
      .clock(clock),
      .reset(reset),
      .start(window_start),
      .fetched(line_fetched),
      .delivered(line_delivered),
      .fetched_total(fetched_total),
      .delivered_total(delivered_total)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      next_state = state;
      next_state.accepted = 1'b0;
      next_state.retry = request_valid && (state.fsm != prefetch_ctrl_pkg::st_idle || slots_full);
      next_state.read_data = '0;
      next_state.outstanding = slots_used;
      // register write, reserved bits masked off
      if (cfg_write && hit_control(cfg_address) && generic_mode) // see R1
      begin
         next_state.control = cfg_write_data[23:0] & `DMA_WIN_CTRL_MASK; // see R14
      end
      // read data for the cycle after the strobe; unmapped reads zero
      if (cfg_read && hit_control(cfg_address) && generic_mode) // see R1
      begin
         next_state.read_data = {8'h00, state.control & `DMA_WIN_CTRL_MASK}; // see R14
      end
      unique case (state.fsm)
         prefetch_ctrl_pkg::st_idle:
         begin
            next_state.fetch = 1'b0;
            next_state.reconnect = 1'b0;
            if (window_start)
            begin
               next_state.accepted = 1'b1;
               next_state.active = chosen;
               next_state.cmd = prefetch_ctrl_pkg::read_cmd_type'(new_cmd);
               next_state.window_used = request_in_dma_window && generic_mode;
               next_state.single = !does_prefetch(new_cmd, chosen); // see R11
               next_state.fsm = prefetch_ctrl_pkg::st_fetch;
            end
         end
         prefetch_ctrl_pkg::st_fetch:
         begin
            // fetch until the first line plus count, or the initial count if larger, is in
            next_state.fetch = fetched_next < {1'b0, fill_goal}; // see R3 see R8 see R10
            if (fetched_total >= initial_need)
            begin
               next_state.reconnect = 1'b1;
            end
            if (!next_state.fetch)
            begin
               next_state.fsm = prefetch_ctrl_pkg::st_deliver;
            end
         end
         prefetch_ctrl_pkg::st_deliver:
         begin
            next_state.reconnect = 1'b1;
            // moving window: one line more per line delivered
            // the request stands until the link returns the extra line
            next_state.fetch = continuous && prefetching && (fetched_next < window_goal); // see R5 see R6 see R12
            if (request_done)
            begin
               next_state.fsm = prefetch_ctrl_pkg::st_drain;
            end
         end
         prefetch_ctrl_pkg::st_drain:
         begin
            next_state.fetch = 1'b0;
            next_state.reconnect = 1'b0;
            next_state.single = 1'b0;
            next_state.fsm = prefetch_ctrl_pkg::st_idle;
         end
         default:
         begin
            next_state.fsm = prefetch_ctrl_pkg::st_idle;
         end
      endcase
      // warm reset restores all writable fields
      if (warm_reset)
      begin
         next_state.control = `DMA_WIN_CTRL_RESET; // see R13
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         state <= '0;
         state.control <= `DMA_WIN_CTRL_RESET; // see R12
         state.fsm <= prefetch_ctrl_pkg::st_idle;
         state.cmd <= prefetch_ctrl_pkg::cmd_none;
      end
      else
      begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign cfg_read_data = state.read_data;
   assign request_accepted = state.accepted;
   assign request_retry = state.retry;
   assign fetch_line = state.fetch;
   assign reconnect_allowed = state.reconnect;
   assign single_word_only = state.single;
   assign window_controls_used = state.window_used;
   assign outstanding = state.outstanding;
endmodule

// ---- src/line_window_counter.sv ----
`timescale 1ns/10ps
`include "prefetch_ctrl_regs.svh"
// tracks lines fetched ahead of delivery for one read
module line_window_counter
#(
   parameter int width = 4
)
(
   input wire logic clock,
   input wire logic reset,
   input wire logic start,
   input wire logic fetched,
   input wire logic delivered,
   output logic [width-1:0] fetched_total,
   output logic [width-1:0] delivered_total
);
   typedef struct packed
   {
      logic [width-1:0] fetched_total;
      logic [width-1:0] delivered_total;
   } window_state_type;

   window_state_type state;
   window_state_type next_state;

   // refuse counters too narrow for eight lines
   if (width < 4)
   begin
      $error("width must be at least 4");
   end

   assign fetched_total = state.fetched_total;
   assign delivered_total = state.delivered_total;

   // totals restart with each read and saturate
   always_comb
   begin
      next_state = state;
      if (start)
      begin
         next_state = '0;
      end
      else
      begin
         if (fetched && state.fetched_total != '1)
         begin
            next_state.fetched_total = state.fetched_total + width'(1);
         end
         if (delivered && state.delivered_total != state.fetched_total)
         begin
            next_state.delivered_total = state.delivered_total + width'(1);
         end
      end
   end

   // state register
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end
endmodule

// ---- src/prefetch_ctrl_pkg.sv ----
package prefetch_ctrl_pkg;
   // pci read command kinds
   typedef enum logic [1:0]
   {
      cmd_plain = 2'h0,
      cmd_line = 2'h1,
      cmd_multiple = 2'h2,
      cmd_none = 2'h3
   } read_cmd_type;

   // prefetch engine states
   typedef enum logic [3:0]
   {
      st_idle = 4'h1,
      st_fetch = 4'h2,
      st_deliver = 4'h4,
      st_drain = 4'h8
   } fetch_state_type;
endpackage

// ---- src/prefetch_ctrl_regs.svh ----
`ifndef PREFETCH_CTRL_REGS_SVH
`define PREFETCH_CTRL_REGS_SVH
// byte offsets in configuration space
`define RSVD_SLOT_A_OFFSET 8'h5A
`define DMA_WIN_CTRL_OFFSET 8'h5C
`define CFG_ADDR_WIDTH 8
`define CFG_DATA_WIDTH 32
// field positions
`define F_LINE_INIT_HI 21
`define F_LINE_INIT_LO 19
`define F_MULT_INIT_HI 18
`define F_MULT_INIT_LO 16
`define F_LINE_CONT 11
`define F_MULT_CONT 10
`define F_DELAYED_HI 9
`define F_DELAYED_LO 8
`define F_LINE_COUNT_HI 7
`define F_LINE_COUNT_LO 5
`define F_MULT_COUNT_HI 4
`define F_MULT_COUNT_LO 2
`define F_PLAIN_PREFETCH 1
`define F_PREFETCH_ENABLE 0
// writable bits and reset value of the control register
`define DMA_WIN_CTRL_MASK 24'h3F0FFF
`define DMA_WIN_CTRL_RESET 24'h000001
`define LINE_COUNT_WIDTH 3
`define SLOT_COUNT_WIDTH 3
`endif
